// [hw/gma_access_top.sv]
// Function
// - The core reaches the GPIO space on a direct port at its own base with no wait state.
// - Core and DMA reach the same registers through the crossbar bridge slot base.
// - An alias at bridge slot 15 reaches the very same storage as the other paths.
// - All decorated read-modify-write operations are served at the slot-15 alias.
// - A pin muxed to the two-wire bus function is driven open drain automatically.
// - Serial transmit pins go open drain when the system option bit asks for it.
// - Every pull device is a pull-up except the debug clock pin, and this is readable.
// - A pin's pull device is enabled by the pull enable field software writes.
// - Bridge slot 15 decodes as an alias of the last bridge slot (255), same module.
`timescale 1ns/1ns
`default_nettype none
module gma_access_top
  import gma_pkg::*;
#(
  parameter int NPORT = 5,
  parameter int PW = 32,
  parameter logic [2:0] I2C_ALT = GMA_MUX_I2C_DEF,
  parameter logic [NPORT*PW-1:0] UART_TX_MASK = '0,
  parameter int DBG_CLK_PIN = 0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire gma_dreq_t dreq,
  output gma_rsp_t drsp,
  input wire gma_breq_t breq,
  output logic bready,
  output gma_rsp_t brsp,
  input wire logic [NPORT*PW-1:0] pin_in,
  output logic [NPORT*PW-1:0] pad_out,
  output logic [NPORT*PW-1:0] pad_oe,
  input wire logic [NPORT*PW*3-1:0] pin_mux_sel,
  input wire logic [NPORT*PW-1:0] alt_out,
  input wire logic [NPORT*PW-1:0] alt_oe,
  input wire logic [NPORT*PW-1:0] pcr_pull_device_enable,
  input wire logic system_option_reg_five_tx_ode,
  output logic [NPORT*PW-1:0] pad_pull_device_enable,
  output logic [NPORT*PW-1:0] pull_direction_select
);

  localparam int NPIN = NPORT * PW;
  localparam int WORDS = 2 * NPORT;
  localparam int IW = $clog2(WORDS);

  if (NPORT < 1 || NPORT > 8 || PW != 32 || DBG_CLK_PIN >= NPIN) begin : g_chk
    $error("gma_access_top: unsupported port count, width or debug pin");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  gma_dec_t d_dec, b_dec;
  logic d_ok, b_pri, b_ali, b_ok, b_deco, b_refuse;

  assign d_dec = gma_decode(dreq.addr[11:0], NPORT);
  assign d_ok = (dreq.addr[31:GMA_SPACE_LSB] == GMA_DIRECT_BASE[31:GMA_SPACE_LSB])
                && d_dec.hit;
  assign b_dec = gma_decode(breq.addr[11:0], NPORT);
  // Primary slot and its alias select one module and one storage
  assign b_pri = breq.addr[31:GMA_SPACE_LSB] == GMA_BRIDGE_BASE[31:GMA_SPACE_LSB];
  assign b_ali = breq.addr[31:GMA_SPACE_LSB] == GMA_ALIAS_BASE[31:GMA_SPACE_LSB];
  assign b_ok = (b_pri || b_ali) && b_dec.hit;
  assign b_deco = breq.op != GMA_BOP_NONE;

  // Decorations need a storage word; load-style ones only as reads, logic ones only as writes.
  // The primary slot keeps only the logic subset, the alias serves all of them.
  always_comb begin
    b_refuse = 1'b0;
    if (b_deco) begin
      b_refuse = !(b_dec.kind == GMA_REG_DOUT || b_dec.kind == GMA_REG_DIR);
      if (breq.op == GMA_BOP_LAC1 || breq.op == GMA_BOP_LAS1) begin
        b_refuse = b_refuse || breq.write || b_pri;
      end else begin
        b_refuse = b_refuse || !breq.write;
      end
    end
  end

  // Plain write effect of each register kind
  function automatic gma_wop_t kind_wop(input logic [3:0] kind);
    unique case (kind)
      GMA_REG_DOUT, GMA_REG_DIR: kind_wop = GMA_WOP_STORE;
      GMA_REG_SET: kind_wop = GMA_WOP_OR;
      GMA_REG_CLR: kind_wop = GMA_WOP_ANDN;
      GMA_REG_TOG: kind_wop = GMA_WOP_XOR;
      default: kind_wop = GMA_WOP_NONE;
    endcase
  endfunction

  function automatic logic [IW-1:0] word_idx(input gma_dec_t d);
    word_idx = IW'({d.port, d.kind == GMA_REG_DIR});
  endfunction

  // ----------------------------------------------------------------
  // Write arbitration
  // ----------------------------------------------------------------
  logic wr_en, d_wr;
  logic [IW-1:0] wr_idx;
  gma_wop_t wr_op;
  logic [31:0] wr_data, bit_mask;

  // The direct port never waits; the bridge is held off while it writes.
  // One write port means no two updates can interleave on a word.
  assign d_wr = dreq.valid && dreq.write;
  assign bready = !d_wr;
  assign bit_mask = 32'h0000_0001 << breq.wdata[4:0];

  always_comb begin
    wr_en = 1'b0;
    wr_idx = word_idx(d_dec);
    wr_op = GMA_WOP_NONE;
    wr_data = dreq.wdata;
    if (d_wr && d_ok) begin
      wr_op = kind_wop(d_dec.kind);
      wr_en = wr_op != GMA_WOP_NONE;
    end else if (breq.valid && !d_wr && b_ok && !b_refuse) begin
      wr_idx = word_idx(b_dec);
      wr_data = breq.wdata;
      unique case (breq.op)
        GMA_BOP_NONE: wr_op = breq.write ? kind_wop(b_dec.kind) : GMA_WOP_NONE;
        GMA_BOP_AND: wr_op = GMA_WOP_AND;
        GMA_BOP_OR: wr_op = GMA_WOP_OR;
        GMA_BOP_XOR: wr_op = GMA_WOP_XOR;
        GMA_BOP_LAC1: wr_op = GMA_WOP_ANDN;
        GMA_BOP_LAS1: wr_op = GMA_WOP_OR;
        default: wr_op = GMA_WOP_NONE;
      endcase
      if (breq.op == GMA_BOP_LAC1 || breq.op == GMA_BOP_LAS1) begin
        wr_data = bit_mask;
      end
      wr_en = wr_op != GMA_WOP_NONE;
    end
  end

  logic [31:0] rd_a, rd_b;
  logic [WORDS*32-1:0] words;

  gma_regmem #(.WORDS(WORDS), .IW(IW)) u_mem (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .rd_idx_a(word_idx(d_dec)),
    .rd_idx_b(word_idx(b_dec)),
    .rd_data_a(rd_a),
    .rd_data_b(rd_b),
    .all_words(words)
  );

  // ----------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------
  logic d_val_q, d_val_d, d_err_q, d_err_d, b_val_q, b_val_d, b_err_q, b_err_d;
  logic [3:0] d_kind_q, d_kind_d, b_kind_q, b_kind_d;
  logic [2:0] d_port_q, d_port_d, b_port_q, b_port_d;
  logic [NPIN-1:0] pdir_q;

  // Every direct request is answered on the next edge
  always_comb begin
    d_val_d = ce && dreq.valid;
    d_err_d = !d_ok;
    d_kind_d = d_dec.kind;
    d_port_d = d_dec.port;
    b_val_d = ce && breq.valid && bready;
    b_err_d = !b_ok || b_refuse;
    b_kind_d = b_dec.kind;
    b_port_d = b_dec.port;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      d_val_q <= 1'b0;
      d_err_q <= 1'b0;
      d_kind_q <= GMA_REG_DOUT;
      d_port_q <= 3'h0;
      b_val_q <= 1'b0;
      b_err_q <= 1'b0;
      b_kind_q <= GMA_REG_DOUT;
      b_port_q <= 3'h0;
    end else if (ce) begin
      d_val_q <= d_val_d;
      d_err_q <= d_err_d;
      d_kind_q <= d_kind_d;
      d_port_q <= d_port_d;
      b_val_q <= b_val_d;
      b_err_q <= b_err_d;
      b_kind_q <= b_kind_d;
      b_port_q <= b_port_d;
    end
  end

  // Set, clear and toggle read as zero; input data come from the filtered pins
  function automatic logic [31:0] rd_sel(input logic err, input logic [3:0] kind,
                                         input logic [2:0] port, input logic [31:0] mem);
    if (err) begin
      rd_sel = 32'h0000_0000;
    end else if (kind == GMA_REG_DIN) begin
      rd_sel = pdir_q[port*PW +: PW];
    end else if (kind == GMA_REG_DOUT || kind == GMA_REG_DIR) begin
      rd_sel = mem;
    end else begin
      rd_sel = 32'h0000_0000;
    end
  endfunction

  assign drsp = '{valid: d_val_q, err: d_err_q, rdata: rd_sel(d_err_q, d_kind_q, d_port_q, rd_a)};
  assign brsp = '{valid: b_val_q, err: b_err_q, rdata: rd_sel(b_err_q, b_kind_q, b_port_q, rd_b)};

  // ----------------------------------------------------------------
  // Pin input filter and pad drive
  // ----------------------------------------------------------------
  logic [NPIN-1:0] s1_q, s2_q, s3_q, pdir_d;
  logic [NPIN-1:0] out_d, oe_d, i2c_sel, uart_od_sel;

  // A pin change counts only once the second and third stage agree
  always_comb begin
    pdir_d = (s3_q & ~(s2_q ^ s3_q)) | (pdir_q & (s2_q ^ s3_q));
  end

  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    logic [2:0] mux;
    logic raw_out, raw_oe, od;
    assign mux = pin_mux_sel[p*3 +: 3];
    assign raw_out = (mux == GMA_MUX_GPIO) ? words[(p/PW)*64 + (p%PW)] : alt_out[p];
    assign raw_oe = (mux == GMA_MUX_GPIO) ? words[(p/PW)*64 + 32 + (p%PW)]
                  : (mux != GMA_MUX_OFF) && alt_oe[p];
    assign i2c_sel[p] = mux == I2C_ALT;
    assign uart_od_sel[p] = system_option_reg_five_tx_ode && UART_TX_MASK[p]
                            && (mux != GMA_MUX_GPIO) && (mux != GMA_MUX_OFF);
    // Open drain: only a low is driven, a high releases the pad to its pull-up
    assign od = i2c_sel[p] || uart_od_sel[p];
    assign out_d[p] = od ? 1'b0 : raw_out;
    assign oe_d[p] = od ? (raw_oe && !raw_out) : raw_oe;
    // Pull direction is hard wired; only the debug clock pin pulls down
    assign pull_direction_select[p] = (p != DBG_CLK_PIN);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pdir_q <= '0;
      pad_out <= '0;
      pad_oe <= '0;
      pad_pull_device_enable <= '0;
    end else if (ce) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pdir_q <= pdir_d;
      pad_out <= out_d;
      pad_oe <= oe_d;
      pad_pull_device_enable <= pcr_pull_device_enable;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_bridge_take;
    ce && breq.valid && bready;
  endsequence

  sequence s_alias_plain_dout;
    s_bridge_take ##0 (b_ali && b_dec.hit && breq.write && !b_deco
                       && b_dec.kind == GMA_REG_DOUT);
  endsequence

  a_direct_zero_wait: assert property ((ce && dreq.valid) |=> drsp.valid)
    else $error("direct request not answered on the next edge");
  a_bridge_answer: assert property (s_bridge_take |=> brsp.valid)
    else $error("bridge request not answered");
  a_alias_storage: assert property (s_alias_plain_dout |=>
                                    words[$past(b_dec.port)*64 +: 32] == $past(breq.wdata))
    else $error("alias write did not reach shared storage");
  a_alias_full_ops: assert property ((s_bridge_take ##0 (b_ali && b_dec.hit && !breq.write
      && b_dec.kind == GMA_REG_DOUT && breq.op inside {GMA_BOP_LAC1, GMA_BOP_LAS1}))
      |=> brsp.valid && !brsp.err)
    else $error("load-and-modify refused at alias");
  a_i2c_open_drain: assert property (ce |=> (pad_out & $past(i2c_sel)) == '0)
    else $error("two-wire pin driven high");
  a_uart_open_drain: assert property (ce |=> (pad_out & $past(uart_od_sel)) == '0)
    else $error("transmit pin driven high in open drain");
  a_pull_direction: assert property (!pull_direction_select[DBG_CLK_PIN]
      && $countones(pull_direction_select) == NPIN - 1)
    else $error("pull direction wrong");
  a_pull_enable_sw: assert property (ce |=> pad_pull_device_enable
                                     == $past(pcr_pull_device_enable))
    else $error("pull enable does not follow control field");
  // Either slot must return the one shared word, not a copy
  a_slot_alias: assert property ((s_bridge_take ##0 ((b_pri || b_ali) && b_dec.hit && !breq.write
      && !b_deco && b_dec.kind == GMA_REG_DOUT)) |=> brsp.valid && !brsp.err
      && brsp.rdata == $past(words[b_dec.port*64 +: 32]))
    else $error("slot alias not decoded");
  a_direct_wins: assert property ((ce && dreq.valid && dreq.write && breq.valid)
      |=> !brsp.valid)
    else $error("bridge accepted during direct write");

endmodule // gma_access_top
`default_nettype wire

// [hw/gma_pkg.sv]
`default_nettype none
package gma_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] GMA_DIRECT_BASE = 32'hf800_0000;
  localparam logic [31:0] GMA_BRIDGE_BASE = 32'h400f_f000;
  localparam logic [31:0] GMA_ALIAS_BASE = 32'h4000_f000;
  localparam int GMA_SPACE_LSB = 12;
  localparam int GMA_PORT_LSB = 6;
  localparam int GMA_REG_LSB = 2;

  // ----------------------------------------------------------------
  // Register offsets within one port, as word indices
  // ----------------------------------------------------------------
  localparam logic [3:0] GMA_REG_DOUT = 4'h0;
  localparam logic [3:0] GMA_REG_SET = 4'h1;
  localparam logic [3:0] GMA_REG_CLR = 4'h2;
  localparam logic [3:0] GMA_REG_TOG = 4'h3;
  localparam logic [3:0] GMA_REG_DIN = 4'h4;
  localparam logic [3:0] GMA_REG_DIR = 4'h5;

  // ----------------------------------------------------------------
  // Reset values and pin mux codes
  // ----------------------------------------------------------------
  localparam logic [31:0] GMA_DOUT_RST = 32'h0000_0000;
  localparam logic [31:0] GMA_DIR_RST = 32'h0000_0000;
  localparam logic [2:0] GMA_MUX_OFF = 3'h0;
  localparam logic [2:0] GMA_MUX_GPIO = 3'h1;
  localparam logic [2:0] GMA_MUX_I2C_DEF = 3'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GMA_WOP_NONE = 3'h0, GMA_WOP_STORE = 3'h1, GMA_WOP_OR = 3'h2,
    GMA_WOP_ANDN = 3'h3, GMA_WOP_XOR = 3'h4, GMA_WOP_AND = 3'h5
  } gma_wop_t;

  // Decorations carried by a bridge access for the write arbitration in gma_access_top
  typedef enum logic [2:0] {
    GMA_BOP_NONE = 3'h0, GMA_BOP_AND = 3'h1, GMA_BOP_OR = 3'h2,
    GMA_BOP_XOR = 3'h3, GMA_BOP_LAC1 = 3'h4, GMA_BOP_LAS1 = 3'h5
  } gma_bop_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } gma_dreq_t;

  typedef struct packed {
    logic valid;
    logic write;
    gma_bop_t op;
    logic [31:0] addr;
    logic [31:0] wdata;
  } gma_breq_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } gma_rsp_t;

  typedef struct packed {
    logic hit;
    logic [3:0] kind;
    logic [2:0] port;
  } gma_dec_t;

  // Offset decode inside the 4 KB window, shared by every path
  function automatic gma_dec_t gma_decode(input logic [11:0] ofs, input int nport);
    gma_dec_t d;
    d.kind = ofs[GMA_REG_LSB +: 4];
    d.port = ofs[GMA_PORT_LSB +: 3];
    d.hit = (ofs[1:0] == 2'h0) && (d.kind <= GMA_REG_DIR) && (32'(d.port) < nport)
            && (ofs[11:9] == 3'h0);
    return d;
  endfunction

endpackage
`default_nettype wire

// [hw/gma_regmem.sv]
`timescale 1ns/1ns
`default_nettype none
module gma_regmem
  import gma_pkg::*;
#(
  parameter int WORDS = 10,
  parameter int IW = 4
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [IW-1:0] wr_idx,
  input wire gma_wop_t wr_op,
  input wire logic [31:0] wr_data,
  input wire logic [IW-1:0] rd_idx_a,
  input wire logic [IW-1:0] rd_idx_b,
  output logic [31:0] rd_data_a,
  output logic [31:0] rd_data_b,
  output logic [WORDS*32-1:0] all_words
);

  if (WORDS < 2 || (1 << IW) < WORDS) begin : g_chk
    $error("gma_regmem: index width too small for WORDS");
  end

  logic [31:0] mem_q [WORDS];
  logic [31:0] mem_d [WORDS];
  logic [31:0] rda_d, rdb_d;

  // Whole-word update in one cycle keeps every masked change atomic
  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en && (32'(wr_idx) < WORDS)) begin
      unique case (wr_op)
        GMA_WOP_STORE: mem_d[wr_idx] = wr_data;
        GMA_WOP_OR: mem_d[wr_idx] = mem_q[wr_idx] | wr_data;
        GMA_WOP_ANDN: mem_d[wr_idx] = mem_q[wr_idx] & ~wr_data;
        GMA_WOP_XOR: mem_d[wr_idx] = mem_q[wr_idx] ^ wr_data;
        GMA_WOP_AND: mem_d[wr_idx] = mem_q[wr_idx] & wr_data;
        default: mem_d[wr_idx] = mem_q[wr_idx];
      endcase
    end
    // Reads show the value before this cycle's update (load-and-modify)
    rda_d = (32'(rd_idx_a) < WORDS) ? mem_q[rd_idx_a] : 32'h0000_0000;
    rdb_d = (32'(rd_idx_b) < WORDS) ? mem_q[rd_idx_b] : 32'h0000_0000;
  end

  // Even words hold output data, odd words hold direction
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= (i % 2 == 1) ? GMA_DIR_RST : GMA_DOUT_RST;
      end
      rd_data_a <= 32'h0000_0000;
      rd_data_b <= 32'h0000_0000;
    end else if (ce) begin
      mem_q <= mem_d;
      rd_data_a <= rda_d;
      rd_data_b <= rdb_d;
    end
  end

  for (genvar g = 0; g < WORDS; g++) begin : g_flat
    assign all_words[g*32 +: 32] = mem_q[g];
  end

endmodule // gma_regmem
`default_nettype wire

// [sim/gma_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
module gma_master_model
  import gma_pkg::*;
(
  input wire logic core_clk,
  input wire logic bready,
  input wire gma_rsp_t brsp,
  output var gma_breq_t breq
);
  // ----------------------------------------------------------------
  // Bridge master: core or DMA behind the crossbar
  // ----------------------------------------------------------------
  initial begin
    breq = '0;
  end

  // Holds the request until bready is seen high, then lets the lines go stale.
  // The caller picks the decoration; the full set is meant for the alias slot only.
  task automatic xfer(input logic wr, input gma_bop_t op, input logic [31:0] a,
                      input logic [31:0] d, input int stall, output gma_rsp_t r);
    int n;
    n = 0;
    repeat (stall) @(posedge core_clk);
    @(posedge core_clk);
    breq <= '{1'b1, wr, op, a, d};
    @(posedge core_clk);
    while (bready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    // Released lines show inverted values so a stale request never looks valid
    breq <= '{1'b0, ~wr, op, ~a, ~d};
    @(posedge core_clk);
    r = brsp;
  endtask
endmodule // gma_master_model
`default_nettype wire

// [sim/gpio_multiport_access_test.sv]
`timescale 1ns/1ns
`default_nettype none
module gpio_multiport_access_test
  import gma_pkg::*;
;
  localparam int NPIN = 160;
  localparam int DBG = 5;
  localparam logic [NPIN-1:0] TXM = 160'h8;
  logic core_clk, rstn, ce, bready, ode;
  gma_dreq_t dreq;
  gma_breq_t breq;
  gma_rsp_t drsp, brsp, r, r2;
  logic [NPIN-1:0] pin_in, pad_out, pad_oe, alt_out, alt_oe, pcr_pe, pad_pe, pull_dir;
  logic [NPIN*3-1:0] mux;
  logic [31:0] m [10];
  logic [31:0] d, x;
  logic [3:0] k, e4o, e4e;
  int fail_count, total_checks, i, b, p, o, s;

  gma_access_top #(.DBG_CLK_PIN(DBG), .UART_TX_MASK(TXM)) gma_access_top_i (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .dreq(dreq), .drsp(drsp), .breq(breq),
    .bready(bready), .brsp(brsp), .pin_in(pin_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pin_mux_sel(mux), .alt_out(alt_out), .alt_oe(alt_oe), .pcr_pull_device_enable(pcr_pe),
    .system_option_reg_five_tx_ode(ode), .pad_pull_device_enable(pad_pe),
    .pull_direction_select(pull_dir));

  gma_master_model gma_master_model_i (
    .core_clk(core_clk), .bready(bready), .brsp(brsp), .breq(breq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  always #10 core_clk = ~core_clk;

  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read data is compared only when cd is set; writes and refusals carry none
  task automatic chk_rsp(input gma_rsp_t g, input logic e, input logic [31:0] xd, input logic cd);
    total_checks++;
    if (g.valid !== 1'b1 || g.err !== e || (cd && g.rdata !== xd)) begin
      fail_count++;
      $display("wrong value at %0t: rsp %b/%b/%h exp err %b data %h", $time, g.valid, g.err,
               g.rdata, e, xd);
    end
  endtask

  task automatic chk_vec(input logic [NPIN-1:0] g, input logic [NPIN-1:0] xv);
    total_checks++;
    if (g !== xv) begin
      fail_count++;
      $display("wrong value at %0t: pins %h exp %h", $time, g, xv);
    end
  endtask

  function automatic logic [31:0] adr(input int pb, input int pp, input logic [3:0] pk);
    logic [31:0] base;
    base = pb == 0 ? GMA_DIRECT_BASE : (pb == 1 ? GMA_BRIDGE_BASE : GMA_ALIAS_BASE);
    return base | (32'(pp) << GMA_PORT_LSB) | (32'(pk) << GMA_REG_LSB);
  endfunction

  // Direct port answers one edge after the request edge, no wait state
  task automatic acc(input int pb, input logic wr, input gma_bop_t op, input logic [31:0] a,
                     input logic [31:0] wd, output gma_rsp_t g);
    if (pb == 0) begin
      @(posedge core_clk);
      dreq <= '{1'b1, wr, a, wd};
      @(posedge core_clk);
      dreq <= '{1'b0, ~wr, ~a, ~wd};
      @(posedge core_clk);
      g = drsp;
    end else begin
      gma_master_model_i.xfer(wr, op, a, wd, $urandom % 3, g);
    end
  endtask

  initial begin
    #(20 * 6000);
    fail_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 0;
    rstn = 0;
    ce = 1;
    ode = 0;
    dreq = '0;
    pin_in = '0;
    alt_out = '0;
    alt_oe = '1;
    pcr_pe = '0;
    mux = {468'h0, 3'h3, 3'h3, GMA_MUX_I2C_DEF, GMA_MUX_GPIO};
    void'($urandom(32'hc2eb));
    for (i = 0; i < 10; i++) m[i] = '0;
    repeat (4) @(posedge core_clk);
    rstn <= 1;
    // Same word seen from all three paths after a write through each path in turn
    for (i = 0; i < 10; i++) begin
      p = $urandom % 5;
      s = i % 2;
      k = s ? GMA_REG_DIR : GMA_REG_DOUT;
      d = $urandom;
      acc(i % 3, 1, GMA_BOP_NONE, adr(i % 3, p, k), d, r);
      chk_rsp(r, 0, 0, 0);
      m[2*p+s] = d;
      for (b = 0; b < 3; b++) begin
        acc(b, 0, GMA_BOP_NONE, adr(b, p, k), $urandom, r);
        chk_rsp(r, 0, d, 1);
      end
    end
    // Set, clear and toggle words; they read back as zero
    for (k = GMA_REG_SET; k <= GMA_REG_TOG; k++) begin
      p = $urandom % 5;
      d = $urandom;
      acc(0, 1, GMA_BOP_NONE, adr(0, p, k), d, r);
      chk_rsp(r, 0, 0, 0);
      if (k == GMA_REG_SET) m[2*p] = m[2*p] | d;
      else if (k == GMA_REG_CLR) m[2*p] = m[2*p] & ~d;
      else m[2*p] = m[2*p] ^ d;
      acc(1, 0, GMA_BOP_NONE, adr(1, p, k), 0, r);
      chk_rsp(r, 0, 0, 1);
      acc(2, 0, GMA_BOP_NONE, adr(2, p, GMA_REG_DOUT), 0, r);
      chk_rsp(r, 0, m[2*p], 1);
    end
    // Decorated word operations on both bridge slots
    for (o = 1; o <= 3; o++) begin
      for (b = 1; b < 3; b++) begin
        p = $urandom % 5;
        s = $urandom % 2;
        k = s ? GMA_REG_DIR : GMA_REG_DOUT;
        d = $urandom;
        acc(b, 1, gma_bop_t'(o[2:0]), adr(b, p, k), d, r);
        chk_rsp(r, 0, 0, 0);
        x = m[2*p+s];
        m[2*p+s] = o == 1 ? x & d : (o == 2 ? x | d : x ^ d);
        acc(0, 0, GMA_BOP_NONE, adr(0, p, k), 0, r);
        chk_rsp(r, 0, m[2*p+s], 1);
      end
    end
    // Bit load-and-clear/set: served at the alias, refused at the primary slot
    for (o = 4; o <= 5; o++) begin
      for (b = 2; b > 0; b--) begin
        p = $urandom % 5;
        d = $urandom % 32;
        x = m[2*p];
        acc(b, 0, gma_bop_t'(o[2:0]), adr(b, p, GMA_REG_DOUT), d, r);
        chk_rsp(r, b == 1, x, b == 2);
        if (b == 2) m[2*p][d[4:0]] = (o == 5);
        acc(0, 0, GMA_BOP_NONE, adr(0, p, GMA_REG_DOUT), 0, r);
        chk_rsp(r, 0, m[2*p], 1);
      end
    end
    // Refusals leave storage alone
    acc(0, 1, GMA_BOP_NONE, adr(0, 1, GMA_REG_DOUT) | 32'h2, $urandom, r);
    chk_rsp(r, 1, 0, 0);
    acc(1, 1, GMA_BOP_NONE, 32'h400e_f040, $urandom, r);
    chk_rsp(r, 1, 0, 0);
    acc(2, 0, GMA_BOP_AND, adr(2, 1, GMA_REG_DOUT), $urandom, r);
    chk_rsp(r, 1, 0, 0);
    acc(2, 0, GMA_BOP_NONE, adr(2, 1, GMA_REG_DOUT), 0, r);
    chk_rsp(r, 0, m[2], 1);
    // Direct store and bridge OR to one word in the same cycle: both land
    d = $urandom;
    x = $urandom;
    fork
      acc(0, 1, GMA_BOP_NONE, adr(0, 3, GMA_REG_DOUT), d, r);
      gma_master_model_i.xfer(1, GMA_BOP_OR, adr(1, 3, GMA_REG_DOUT), x, 0, r2);
    join
    chk_rsp(r, 0, 0, 0);
    chk_rsp(r2, 0, 0, 0);
    m[6] = d | x;
    acc(2, 0, GMA_BOP_NONE, adr(2, 3, GMA_REG_DOUT), 0, r);
    chk_rsp(r, 0, m[6], 1);
    // Pads: GPIO, two-wire, plain peripheral and transmit pin
    @(posedge core_clk);
    pin_in <= {$urandom, $urandom, $urandom, $urandom, $urandom};
    pcr_pe <= {$urandom, $urandom, $urandom, $urandom, $urandom};
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      alt_out <= {NPIN{i[0]}};
      ode <= i[1];
      repeat (3) @(negedge core_clk);
      e4o = {i[1] ? 1'b0 : i[0], i[0], 1'b0, m[0][0]};
      e4e = {i[1] ? ~i[0] : 1'b1, 1'b1, ~i[0], m[1][0]};
      chk_vec(NPIN'(pad_out[3:0]), NPIN'(e4o));
      chk_vec(NPIN'(pad_oe[3:0]), NPIN'(e4e));
    end
    // Clock enable low: pads must hold the last driven values
    @(posedge core_clk);
    ce <= 0;
    alt_out <= '0;
    repeat (3) @(negedge core_clk);
    chk_vec(NPIN'(pad_out[3:0]), NPIN'(e4o));
    @(posedge core_clk);
    ce <= 1;
    chk_vec(pad_pe, pcr_pe);
    chk_vec(pull_dir, ~(NPIN'(1) << DBG));
    // Input word settles through the synchroniser, then reads at the alias
    repeat (8) @(posedge core_clk);
    acc(2, 0, GMA_BOP_NONE, adr(2, 2, GMA_REG_DIN), 0, r);
    chk_rsp(r, 0, pin_in[95:64], 1);
    print_verdict();
  end
endmodule // gpio_multiport_access_test
`default_nettype wire
